// *** port_ctl_pkg.sv ***
// Shared constants, carriers and state codes of the debug port control block
package port_ctl_pkg;

	// Register offsets on the port's own register address
	localparam logic [3:0] ADDR_PHY_A      = 4'h2;
	localparam logic [3:0] ADDR_PHY_B      = 4'h3;
	localparam logic [3:0] ADDR_KEY_STATUS = 4'h7;
	localparam logic [3:0] ADDR_RESET_REQ  = 4'h8;
	localparam logic [3:0] ADDR_CLOCK_CTL  = 4'h9;
	localparam logic [3:0] ADDR_SYS_CTL    = 4'hA;
	localparam logic [3:0] ADDR_SYS_STATUS = 4'hB;
	localparam logic [3:0] ADDR_SCAN       = 4'hC;

	// Field positions
	localparam int GAP_EN_BIT      = 7;
	localparam int PARITY_IGN_BIT  = 5;
	localparam int TIMEOUT_OFF_BIT = 4;
	localparam int SIG_OFF_BIT     = 3;
	localparam int NACK_OFF_BIT    = 4;
	localparam int CONT_OFF_BIT    = 3;
	localparam int DISABLE_BIT     = 2;
	localparam int KEY_UROW_BIT    = 5;
	localparam int KEY_PROG_BIT    = 4;
	localparam int KEY_ERASE_BIT   = 3;
	localparam int FINISH_BIT      = 1;
	localparam int SYSTEM_CLOCK_REQUEST_BIT      = 0;

	// Writable masks and reset values
	localparam logic [7:0] PHY_A_MASK      = 8'hBF;
	localparam logic [7:0] PHY_A_RESET     = 8'h00;
	localparam logic [1:0] CLKSEL_RESET    = 2'h3;
	localparam logic [1:0] CLKSEL_RESERVED = 2'h0;
	localparam logic [7:0] RESET_SIGNATURE = 8'h59;
	localparam logic [2:0] GUARD_OFF       = 3'h7;
	localparam logic [7:0] GUARD_LONGEST   = 8'h80;

	// Timing in port clock cycles, reply queue depth and byte width
	localparam int         CHAR_BITS           = 12;
	localparam logic [7:0] GAP_CYCLES          = 8'(2 * CHAR_BITS);
	localparam int         TIMEOUT_PORT_CYCLES = 65536;
	localparam int         FIFO_DEPTH          = 16;
	localparam int         BYTE_W              = 8;

	// Register access from the link's instruction decoder
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// Physical-layer settings handed to the line logic
	typedef struct packed {
		logic       gap_en;
		logic       parity_ignore;
		logic       timeout_detect_off;
		logic       response_signature_off;
		logic [2:0] guard_time_select;
		logic       negative_ack_off;
		logic       contention_detect_off;
	} phy_cfg_s;

	// Levels arriving from the system clock domain
	typedef struct packed {
		logic       in_reset;
		logic       asleep;
		logic       prog_ready;
		logic       user_row_ready;
		logic       memory_locked;
		logic [2:0] scan;
	} sys_status_s;

	localparam sys_status_s SYS_STATUS_RESET = 8'h08;

	// Reply byte scheduler
	typedef enum logic [3:0] {
		TX_IDLE  = 4'h1,
		TX_GUARD = 4'h2,
		TX_SEND  = 4'h4,
		TX_GAP   = 4'h8
	} tx_state_e;

endpackage

// *** byte_fifo.sv ***
// Flop-based first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;

	// Extra pointer bit tells full from empty
	assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

	// Storage writes
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// *** port_control.sv ***
// Control and status registers of the single-wire debug port
//
// Contract
// - Gap enable puts two idle characters between bytes
// - Parity ignore suppresses parity error reports
// - Response time-out after 65536 cycles unless disabled
// - Signature off stops response signatures
// - Guard field sets turnaround idle cycles
// - Negative-ack off suppresses reset-abort signature
// - Contention off stops collision detection and reports
// - Disable write clears configuration, keys, clock request
// - Key status shows each active key
// - Programming key clears when programming ends
// - Erase key clears when erase ends
// - Signature 0x59 holds system reset, else released
// - Reset register reads held reset in bit zero
// - Clock select codes, default 4 MHz, zero reserved
// - Finish bit works only with user-row key
// - Clock request keeps system clock in sleep
// - Clock request set on enable, cleared on disable
// - Reset-active status sticky, cleared by reading
// - Asleep status follows system sleep state
// - Program-ready shown; host resets system after
// - User-row-ready shown; host ends with finish
// - Registers only reachable through the port
`timescale 1ns/100ps
`default_nettype none
module port_control #(
	parameter int TIMEOUT_CYCLES = port_ctl_pkg::TIMEOUT_PORT_CYCLES
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  var  port_ctl_pkg::reg_req_s   reg_req,
	output logic [7:0]                    reg_rdata,
	input  wire logic                     port_enable,
	output logic                          port_clock_request,
	output logic                          port_reset,
	output logic [1:0]                    port_clock_select,
	output port_ctl_pkg::phy_cfg_s        phy_cfg,
	input  wire logic                     rx_parity_fault,
	output logic                          parity_error,
	input  wire logic                     rx_contention_fault,
	output logic                          contention_error,
	input  wire logic                     reset_during_access,
	output logic                          nack_send,
	input  wire logic                     access_busy,
	input  wire logic                     access_done,
	output logic                          timeout_error,
	input  wire logic                     user_row_key_set,
	input  wire logic                     memory_program_key_set,
	input  wire logic                     erase_key_set,
	input  wire logic                     program_done,
	input  wire logic                     erase_done,
	output logic                          user_row_finish,
	output logic                          system_reset_signature,
	output logic                          system_clock_request,
	input  var  port_ctl_pkg::sys_status_s sys_status_in,
	input  wire logic                     reply_valid,
	output logic                          reply_ready,
	input  wire logic [7:0]               reply_data,
	output logic                          tx_valid,
	input  wire logic                     tx_ready,
	output logic [7:0]                    tx_data,
	output logic                          tx_signature_allowed
);
	// Register access exists only on reg_req from the link decoder

	logic [7:0]                phy_a_reg;
	logic [1:0]                phy_b_reg;
	logic [2:0]                key_reg;
	logic                      reset_hold_reg;
	logic [1:0]                clksel_reg;
	logic                      system_clock_request_reg;
	logic                      port_active_reg;
	logic                      finish_reg;
	logic                      reset_seen_reg;
	logic                      port_reset_reg;
	logic                      nack_reg;
	logic                      parity_err_reg;
	logic                      contention_err_reg;
	logic                      timeout_reg;
	logic [16:0]               wait_cnt_reg;
	port_ctl_pkg::sys_status_s sync1_reg;
	port_ctl_pkg::sys_status_s sync2_reg;
	port_ctl_pkg::tx_state_e   tx_state_reg;
	logic [7:0]                tx_cnt_reg;
	logic                      disable_wr;
	logic                      fifo_valid;
	logic                      fifo_ready;
	logic [7:0]                fifo_data;
	logic                      tx_take;

	// Guard field decode, used by the turnaround scheduler
	function automatic logic [7:0] guard_cycles(input logic [2:0] code);
		if (code == port_ctl_pkg::GUARD_OFF) begin
			guard_cycles = 8'h00;
		end else begin
			guard_cycles = port_ctl_pkg::GUARD_LONGEST >> code;
		end
	endfunction

	// Address match for a write
	function automatic logic wr_hit(input port_ctl_pkg::reg_req_s r,
	                                input logic [3:0] a);
		wr_hit = r.wr && (r.addr == a);
	endfunction

	assign disable_wr = wr_hit(reg_req, port_ctl_pkg::ADDR_PHY_B) &&
		reg_req.wdata[port_ctl_pkg::DISABLE_BIT];

	// System-domain levels pass two flops before use
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= port_ctl_pkg::SYS_STATUS_RESET;
			sync2_reg <= port_ctl_pkg::SYS_STATUS_RESET;
		end else begin
			sync1_reg <= sys_status_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Physical-layer configuration; a disable write wipes it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phy_a_reg <= port_ctl_pkg::PHY_A_RESET;
			phy_b_reg <= '0;
		end else if (disable_wr) begin
			phy_a_reg <= port_ctl_pkg::PHY_A_RESET;
			phy_b_reg <= '0;
		end else begin
			if (wr_hit(reg_req, port_ctl_pkg::ADDR_PHY_A)) begin
				phy_a_reg <= reg_req.wdata & port_ctl_pkg::PHY_A_MASK;
			end
			if (wr_hit(reg_req, port_ctl_pkg::ADDR_PHY_B)) begin
				phy_b_reg <= {reg_req.wdata[port_ctl_pkg::NACK_OFF_BIT],
				              reg_req.wdata[port_ctl_pkg::CONT_OFF_BIT]};
			end
		end
	end

	assign phy_cfg.gap_en                 = phy_a_reg[port_ctl_pkg::GAP_EN_BIT];
	assign phy_cfg.parity_ignore          =
		phy_a_reg[port_ctl_pkg::PARITY_IGN_BIT];
	assign phy_cfg.timeout_detect_off     =
		phy_a_reg[port_ctl_pkg::TIMEOUT_OFF_BIT];
	assign phy_cfg.response_signature_off = phy_a_reg[port_ctl_pkg::SIG_OFF_BIT];
	assign phy_cfg.guard_time_select      = phy_a_reg[2:0];
	assign phy_cfg.negative_ack_off       = phy_b_reg[1];
	assign phy_cfg.contention_detect_off  = phy_b_reg[0];
	assign tx_signature_allowed = !phy_cfg.response_signature_off;

	// Line fault reports, gated by their disable bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			parity_err_reg     <= 1'b0;
			contention_err_reg <= 1'b0;
			nack_reg           <= 1'b0;
		end else begin
			parity_err_reg     <= rx_parity_fault &&
				!phy_cfg.parity_ignore;
			contention_err_reg <= rx_contention_fault &&
				!phy_cfg.contention_detect_off;
			nack_reg           <= reset_during_access &&
				!phy_cfg.negative_ack_off;
		end
	end

	assign parity_error     = parity_err_reg;
	assign contention_error = contention_err_reg;
	assign nack_send        = nack_reg;

	// Access-layer response watchdog; one pulse per stalled access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt_reg <= '0;
			timeout_reg  <= 1'b0;
		end else begin
			timeout_reg <= 1'b0;
			if (!access_busy || access_done) begin
				wait_cnt_reg <= '0;
			end else if (wait_cnt_reg == 17'(TIMEOUT_CYCLES - 1)) begin
				wait_cnt_reg <= wait_cnt_reg + 17'h00001;
				timeout_reg  <= !phy_cfg.timeout_detect_off;
			end else if (wait_cnt_reg < 17'(TIMEOUT_CYCLES - 1)) begin
				wait_cnt_reg <= wait_cnt_reg + 17'h00001;
			end
		end
	end

	assign timeout_error = timeout_reg;

	// Key status: a disable write clears every key; else hardware sets win over completion and key-status clears
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			key_reg <= '0;
		end else if (disable_wr) begin
			key_reg <= '0;
		end else begin
			if (user_row_key_set) begin
				key_reg[2] <= 1'b1;
			end else if (wr_hit(reg_req, port_ctl_pkg::ADDR_KEY_STATUS) &&
				!reg_req.wdata[port_ctl_pkg::KEY_UROW_BIT]) begin
				key_reg[2] <= 1'b0;
			end
			if (memory_program_key_set) begin
				key_reg[1] <= 1'b1;
			end else if (program_done) begin
				key_reg[1] <= 1'b0;
			end
			if (erase_key_set) begin
				key_reg[0] <= 1'b1;
			end else if (erase_done) begin
				key_reg[0] <= 1'b0;
			end
		end
	end

	// System reset hold; the port itself keeps running through it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_hold_reg <= 1'b0;
		end else if (wr_hit(reg_req, port_ctl_pkg::ADDR_RESET_REQ)) begin
			reset_hold_reg <= reg_req.wdata ==
				port_ctl_pkg::RESET_SIGNATURE;
		end
	end

	assign system_reset_signature = reset_hold_reg;

	// Port enable state, clock select and clock request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_active_reg <= 1'b0;
			clksel_reg      <= port_ctl_pkg::CLKSEL_RESET;
			system_clock_request_reg      <= 1'b0;
			port_reset_reg  <= 1'b0;
		end else begin
			port_reset_reg <= disable_wr;
			if (disable_wr) begin
				port_active_reg <= 1'b0;
				system_clock_request_reg      <= 1'b0;
				clksel_reg      <= port_ctl_pkg::CLKSEL_RESET;
			end else if (port_enable) begin
				port_active_reg <= 1'b1;
				system_clock_request_reg      <= 1'b1;
				clksel_reg      <= port_ctl_pkg::CLKSEL_RESET;
			end else begin
				// The reserved code is refused so the clock never stops
				if (wr_hit(reg_req, port_ctl_pkg::ADDR_CLOCK_CTL) &&
					reg_req.wdata[1:0] != port_ctl_pkg::CLKSEL_RESERVED) begin
					clksel_reg <= reg_req.wdata[1:0];
				end
				if (wr_hit(reg_req, port_ctl_pkg::ADDR_SYS_CTL)) begin
					system_clock_request_reg <= reg_req.wdata[port_ctl_pkg::SYSTEM_CLOCK_REQUEST_BIT];
				end
			end
		end
	end

	assign port_clock_request   = port_active_reg;
	assign port_reset           = port_reset_reg;
	assign port_clock_select    = clksel_reg;
	assign system_clock_request = system_clock_request_reg;

	// User-row finish strobe, honoured only with the user-row key
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			finish_reg <= 1'b0;
		end else begin
			finish_reg <= wr_hit(reg_req, port_ctl_pkg::ADDR_SYS_CTL) &&
				reg_req.wdata[port_ctl_pkg::FINISH_BIT] && key_reg[2];
		end
	end

	assign user_row_finish = finish_reg;

	// Sticky reset-seen flag; a new reset wins over the read clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_seen_reg <= 1'b0;
		end else if (sync2_reg.in_reset || reset_hold_reg) begin
			reset_seen_reg <= 1'b1;
		end else if (reg_req.rd &&
			reg_req.addr == port_ctl_pkg::ADDR_SYS_STATUS) begin
			reset_seen_reg <= 1'b0;
		end
	end

	// Read data; unmapped offsets and reserved bits read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			unique case (reg_req.addr)
				port_ctl_pkg::ADDR_PHY_A: reg_rdata <= phy_a_reg;
				port_ctl_pkg::ADDR_PHY_B: reg_rdata <= {3'h0, phy_b_reg, 3'h0};
				port_ctl_pkg::ADDR_KEY_STATUS: begin
					reg_rdata <= {2'h0, key_reg, 3'h0};
				end
				port_ctl_pkg::ADDR_RESET_REQ: begin
					reg_rdata <= {7'h00, reset_hold_reg};
				end
				port_ctl_pkg::ADDR_CLOCK_CTL: reg_rdata <= {6'h00, clksel_reg};
				port_ctl_pkg::ADDR_SYS_CTL: reg_rdata <= {7'h00, system_clock_request_reg};
				port_ctl_pkg::ADDR_SYS_STATUS: begin
					reg_rdata <= {2'h0, reset_seen_reg, sync2_reg.asleep,
					              sync2_reg.prog_ready, sync2_reg.user_row_ready,
					              1'b0, sync2_reg.memory_locked};
				end
				port_ctl_pkg::ADDR_SCAN: reg_rdata <= {5'h00, sync2_reg.scan};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Reply bytes queue here so a stalled line holds back the access side
	byte_fifo #(
		.WIDTH(port_ctl_pkg::BYTE_W),
		.DEPTH(port_ctl_pkg::FIFO_DEPTH)
	) reply_fifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.in_valid (reply_valid),
		.in_ready (reply_ready),
		.in_data  (reply_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data (fifo_data)
	);

	assign tx_valid   = (tx_state_reg == port_ctl_pkg::TX_SEND) && fifo_valid;
	assign tx_data    = fifo_data;
	assign fifo_ready = (tx_state_reg == port_ctl_pkg::TX_SEND) && tx_ready;
	assign tx_take    = tx_valid && tx_ready;

	// Reply scheduler: guard before the first byte, gap between bytes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg <= port_ctl_pkg::TX_IDLE;
			tx_cnt_reg   <= 8'h00;
		end else begin
			unique case (tx_state_reg)
				port_ctl_pkg::TX_IDLE: begin
					if (fifo_valid) begin
						if (guard_cycles(phy_cfg.guard_time_select) == 8'h00) begin
							tx_state_reg <= port_ctl_pkg::TX_SEND;
						end else begin
							tx_state_reg <= port_ctl_pkg::TX_GUARD;
							tx_cnt_reg   <=
								guard_cycles(phy_cfg.guard_time_select) - 8'h01;
						end
					end
				end
				port_ctl_pkg::TX_GUARD: begin
					if (tx_cnt_reg == 8'h00) begin
						tx_state_reg <= port_ctl_pkg::TX_SEND;
					end else begin
						tx_cnt_reg <= tx_cnt_reg - 8'h01;
					end
				end
				port_ctl_pkg::TX_SEND: begin
					if (tx_take && phy_cfg.gap_en) begin
						tx_state_reg <= port_ctl_pkg::TX_GAP;
						tx_cnt_reg   <= port_ctl_pkg::GAP_CYCLES - 8'h01;
					end else if (!fifo_valid) begin
						tx_state_reg <= port_ctl_pkg::TX_IDLE;
					end
				end
				port_ctl_pkg::TX_GAP: begin
					// Gap ends a reply only if the queue is empty; a queued byte goes without a guard
					if (tx_cnt_reg == 8'h00) begin
						tx_state_reg <= fifo_valid ? port_ctl_pkg::TX_SEND
						                           : port_ctl_pkg::TX_IDLE;
					end else begin
						tx_cnt_reg <= tx_cnt_reg - 8'h01;
					end
				end
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_guard_two;
		(tx_state_reg == port_ctl_pkg::TX_GUARD)[*2] ##1
		(tx_state_reg == port_ctl_pkg::TX_SEND);
	endsequence

	property p_reset_signature;
		wr_hit(reg_req, port_ctl_pkg::ADDR_RESET_REQ) |=>
		system_reset_signature == ($past(reg_req.wdata) == 8'h59);
	endproperty
	a_reset_signature: assert property (p_reset_signature)
		else $error("reset hold does not follow signature write");

	property p_reset_readback;
		reg_req.rd && reg_req.addr == port_ctl_pkg::ADDR_RESET_REQ |=>
		reg_rdata == {7'h00, $past(reset_hold_reg)};
	endproperty
	a_reset_readback: assert property (p_reset_readback)
		else $error("reset request readback wrong");

	property p_disable_clears;
		disable_wr |=> phy_a_reg == 8'h00 && key_reg == 3'h0 &&
		!system_clock_request && !port_clock_request && port_reset;
	endproperty
	a_disable_clears: assert property (p_disable_clears)
		else $error("port disable left state behind");

	property p_program_key_clear;
		program_done && !memory_program_key_set && !disable_wr |=> !key_reg[1];
	endproperty
	a_program_key_clear: assert property (p_program_key_clear)
		else $error("program key not cleared at end");

	property p_parity_gate;
		parity_error |-> !$past(phy_cfg.parity_ignore) && $past(rx_parity_fault);
	endproperty
	a_parity_gate: assert property (p_parity_gate)
		else $error("parity error reported while ignored");

	property p_timeout_gate;
		timeout_error |-> !$past(phy_cfg.timeout_detect_off) &&
		$past(access_busy);
	endproperty
	a_timeout_gate: assert property (p_timeout_gate)
		else $error("time-out raised while disabled or idle");

	property p_guard_two;
		tx_state_reg == port_ctl_pkg::TX_IDLE && fifo_valid &&
		phy_cfg.guard_time_select == 3'h6 |=> s_guard_two;
	endproperty
	a_guard_two: assert property (p_guard_two)
		else $error("two-cycle guard time wrong");

	property p_gap_length;
		tx_take && phy_cfg.gap_en |=>
		(tx_state_reg == port_ctl_pkg::TX_GAP)[*8] ##16 !tx_valid;
	endproperty
	a_gap_length: assert property (p_gap_length)
		else $error("inter-byte gap too short");

	property p_finish_needs_key;
		user_row_finish |-> $past(key_reg[2]);
	endproperty
	a_finish_needs_key: assert property (p_finish_needs_key)
		else $error("finish accepted without user-row key");

	property p_reset_seen_sticky;
		sync2_reg.in_reset |=> reset_seen_reg;
	endproperty
	a_reset_seen_sticky: assert property (p_reset_seen_sticky)
		else $error("reset-active status lost");

endmodule
`default_nettype wire

// *** link_sink.sv ***
// Debugger-side sink for reply bytes, able to stall the line
`timescale 1ns/100ps
`default_nettype none
module link_sink (
	input  wire logic       clk,
	input  wire logic       stall,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] got[$];
	int         when[$];
	int         cyc = 0;
	// A stalled host holds ready low, so the head byte must wait
	assign tx_ready = !stall;
	// Record each byte with the edge count at which it was taken
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			when.push_back(cyc);
		end
	end
endmodule
`default_nettype wire

// *** tb_port_control.sv ***
// Self-checking bench of the debug port control block
`timescale 1ns/100ps
`default_nettype none
module tb_port_control;
	logic                      clk = 0, rst_n = 0, busy = 0, stall = 0;
	port_ctl_pkg::reg_req_s    req = '0;
	port_ctl_pkg::sys_status_s sys = 8'h08;
	port_ctl_pkg::phy_cfg_s    cfg;
	logic [10:0]               pin = '0;
	wire logic [5:0]           ev;
	logic [7:0]                rdata, rdv = '0, txd;
	logic [1:0]                csel;
	logic                      sig, sclk, pclk, rdy, sok, txv, txr;
	int                        cnt[6] = '{default: 0}, lat[8];
	int                        mismatches = 0, n_checks = 0, t0;
	logic [3:0]                ra[9] = '{4'h2, 4'h3, 4'h7, 4'h8, 4'h9,
	                                     4'hA, 4'hB, 4'hC, 4'h5};
	logic [7:0]                rz[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03,
	                                     8'h00, 8'h01, 8'h00, 8'h00};

	always #2.5 clk = ~clk;

	port_control #(.TIMEOUT_CYCLES(16)) DUT (
		.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
		.port_enable(pin[9]), .port_clock_request(pclk), .port_reset(ev[5]),
		.port_clock_select(csel), .phy_cfg(cfg), .rx_parity_fault(pin[0]),
		.parity_error(ev[0]), .rx_contention_fault(pin[1]),
		.contention_error(ev[1]), .reset_during_access(pin[2]),
		.nack_send(ev[2]), .access_busy(busy), .access_done(pin[3]),
		.timeout_error(ev[3]), .user_row_key_set(pin[4]),
		.memory_program_key_set(pin[5]), .erase_key_set(pin[6]),
		.program_done(pin[7]), .erase_done(pin[8]), .user_row_finish(ev[4]),
		.system_reset_signature(sig), .system_clock_request(sclk),
		.sys_status_in(sys), .reply_valid(pin[10]), .reply_ready(rdy),
		.reply_data(rdv), .tx_valid(txv), .tx_ready(txr), .tx_data(txd),
		.tx_signature_allowed(sok)
	);
	link_sink sink (.clk(clk), .stall(stall), .tx_valid(txv),
		.tx_data(txd), .tx_ready(txr));

	// Tally each output pulse on the edges where it stands
	always @(posedge clk) for (int i = 0; i < 6; i++) cnt[i] += int'(ev[i]);

	task automatic chk(input string nm, input logic [15:0] s, e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask

	// One register access; the extra cycle lets read data settle
	task automatic acc(input logic w, input logic [3:0] ad,
		input logic [7:0] d);
		@(negedge clk);
		req = '{w, !w, ad, w ? d : 8'h00};
		@(negedge clk);
		req = '0;
		@(negedge clk);
		if (!w) chk("register", 16'(rdata), 16'(d));
	endtask

	// One-cycle pulse on an input; bit 10 pushes a reply byte
	task automatic pl(input int i, input logic [7:0] d = 8'h00);
		@(negedge clk);
		pin[i] = 1'b1;
		rdv = d;
		@(negedge clk);
		pin[i] = 1'b0;
	endtask

	task automatic wait_tx(input int n);
		for (int i = 0; i < 400 && sink.got.size() < n; i++) @(negedge clk);
		chk("replies", 16'(sink.got.size()), 16'(n));
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Register reset values first, then each control in turn
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 9; i++) acc(0, ra[i], rz[i]);
		// System domain also in reset, so the sticky flag is set too
		sys = 8'hF2;
		repeat (3) @(negedge clk);
		acc(0, 4'hB, 8'h3C);
		acc(0, 4'hC, 8'h02);
		sys = 8'h08;
		acc(1, 4'h2, 8'hFF);
		acc(0, 4'h2, 8'hBF);
		acc(1, 4'h3, 8'h18);
		chk("phy_cfg", 16'(cfg), 16'h01FF);
		chk("sig_ok", 16'(sok), 16'h0000);
		for (int k = 0; k < 6; k++) begin
			pl(k % 3);
			if (k == 2) acc(1, 4'h2, 8'h00);
			if (k == 2) acc(1, 4'h3, 8'h00);
		end
		// The last pulse is tallied only at the following rising edge
		@(negedge clk);
		for (int i = 0; i < 3; i++)
			chk("gated", 16'(cnt[i]), 16'h0001);
		acc(1, 4'h8, 8'h59);
		chk("sys_reset", 16'(sig), 16'h0001);
		acc(0, 4'h8, 8'h01);
		acc(1, 4'h8, 8'h58);
		chk("sys_reset", 16'(sig), 16'h0000);
		acc(0, 4'hB, 8'h21);
		acc(0, 4'hB, 8'h01);
		acc(1, 4'h9, 8'h01);
		acc(1, 4'h9, 8'h00);
		chk("clock_select", 16'(csel), 16'h0001);
		acc(1, 4'h9, 8'h02);
		acc(0, 4'h9, 8'h02);
		pl(9);
		chk("clock_request", 16'({sclk, pclk}), 16'h0003);
		acc(1, 4'hA, 8'h00);
		acc(0, 4'hA, 8'h00);
		acc(1, 4'hA, 8'h01);
		for (int i = 4; i < 7; i++) pl(i);
		acc(0, 4'h7, 8'h38);
		pl(7);
		acc(0, 4'h7, 8'h28);
		pl(8);
		acc(0, 4'h7, 8'h20);
		acc(1, 4'hA, 8'h03);
		acc(1, 4'h7, 8'h00);
		acc(1, 4'hA, 8'h03);
		chk("finish", 16'(cnt[4]), 16'h0001);
		acc(1, 4'h2, 8'h0F);
		pl(4);
		acc(1, 4'h3, 8'h04);
		chk("port_reset", 16'(cnt[5]), 16'h0001);
		acc(0, 4'h2, 8'h00);
		acc(0, 4'h7, 8'h00);
		acc(0, 4'h9, 8'h03);
		chk("clock_request", 16'({sclk, pclk}), 16'h0000);
		for (int i = 0; i < 2; i++) begin
			acc(1, 4'h2, 8'(i << 4));
			busy = 1'b1;
			repeat (20) @(negedge clk);
			pl(3);
			busy = 1'b0;
		end
		chk("timeout", 16'(cnt[3]), 16'h0001);
		for (int g = 0; g < 8; g++) begin
			acc(1, 4'h2, 8'(g));
			pl(10, 8'(g));
			t0 = sink.cyc;
			wait_tx(g + 1);
			lat[g] = sink.when[g] - t0;
		end
		for (int g = 0; g < 7; g++)
			chk("guard", 16'(lat[g] - lat[7]), 16'(128 >> g));
		for (int k = 0; k < 2; k++) begin
			acc(1, 4'h2, k ? 8'h07 : 8'h87);
			pl(10, 8'h5A);
			pl(10, 8'hA5);
			wait_tx(10 + 2 * k);
			lat[k] = sink.when[9 + 2 * k] - sink.when[8 + 2 * k];
		end
		chk("gap", 16'(lat[0] > 24 && lat[1] < 25), 16'h0001);
		// Fill against a stalled host, then drain in order
		stall = 1'b1;
		for (int i = 0; i < 16; i++) pl(10, 8'(i + 8'hA0));
		chk("reply_ready", 16'(rdy), 16'h0000);
		stall = 1'b0;
		wait_tx(28);
		for (int i = 0; i < 16; i++)
			chk("order", 16'(sink.got[12 + i]), 16'(8'hA0 + i));
		give_verdict;
	end

	// The tests need under a thousand cycles; stop a hang at ten thousand
	initial begin
		#50000;
		mismatches++;
		give_verdict;
	end
endmodule
`default_nettype wire
